// >>> src/tbs_pkg.sv
// Overview of operation
// - update-ir falling edge loads new instruction
// - bypass captures zero leaving capture-dr
// - tdo driver enabled falling edge entering shift-dr
// - one tdi bit shifted per rising edge
// - bypass delays serial stream one stage
// - tdo released falling edge entering exit1-dr
// - update-dr falling edge transfers shifted data
// - sample rising edges, drive falling edges
// - eight-bit ir, capture 10000001, ones bypass
package tbs_pkg;
   localparam int         IR_W        = 8;
   localparam logic [7:0] IR_CAPTURE  = 8'h81;
   localparam logic [7:0] IR_BYPASS   = 8'hFF;
   localparam logic [7:0] IR_RESET    = 8'hFF;
   localparam int         DR_W        = 8;
   localparam int         FIFO_W      = 8;
   localparam int         FIFO_DEPTH  = 16;
   localparam int         SYNC_STAGES = 2;

   typedef enum logic [15:0] {
      ST_RESET   = 16'h0001,
      ST_IDLE    = 16'h0002,
      ST_SEL_DR  = 16'h0004,
      ST_CAP_DR  = 16'h0008,
      ST_SH_DR   = 16'h0010,
      ST_EX1_DR  = 16'h0020,
      ST_PA_DR   = 16'h0040,
      ST_EX2_DR  = 16'h0080,
      ST_UPD_DR  = 16'h0100,
      ST_SEL_IR  = 16'h0200,
      ST_CAP_IR  = 16'h0400,
      ST_SH_IR   = 16'h0800,
      ST_EX1_IR  = 16'h1000,
      ST_PA_IR   = 16'h2000,
      ST_EX2_IR  = 16'h4000,
      ST_UPD_IR  = 16'h8000
   } tbs_state_t;
endpackage : tbs_pkg

// >>> src/tbs_fifo.sv
`timescale 1ns/100ps
module tbs_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          push, pop;

   // handshake and pointer arithmetic
   always_comb begin
      in_ready  = (cnt_q < (AW+1)'(D)); // room for one more word
      out_valid = (cnt_q != '0);
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wr_d      = push ? wr_q + 1'b1 : wr_q;
      rd_d      = pop ? rd_q + 1'b1 : rd_q;
      cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      out_data  = mem_q[rd_q];
   end

   // registers and storage
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule : tbs_fifo

// >>> src/tbs_tap.sv
`timescale 1ns/100ps
module tbs_tap (
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic                     tck,
   input  wire logic                     tms,
   input  wire logic                     tdi,
   output logic                          tdo,
   output logic                          tdo_oe,
   output logic [tbs_pkg::IR_W-1:0]      ir_active,
   output logic                          bypass_sel,
   output logic [tbs_pkg::DR_W-1:0]      dr_parallel,
   output logic                          tlr_state,
   output logic                          word_valid,
   input  wire logic                     word_ready,
   output logic [tbs_pkg::FIFO_W-1:0]    word_data
);
   import tbs_pkg::*;

   // synchronisers for the test port pins
   logic [SYNC_STAGES-1:0] tck_s_q, tms_s_q, tdi_s_q;
   logic                   tck_prev_q;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         // test clock idles high, so no false edge right after reset
         tck_s_q    <= '1;
         tms_s_q    <= '1;
         tdi_s_q    <= '1;
         tck_prev_q <= 1'b1;
      end else begin
         tck_s_q    <= {tck_s_q[0], tck};
         tms_s_q    <= {tms_s_q[0], tms};
         tdi_s_q    <= {tdi_s_q[0], tdi};
         tck_prev_q <= tck_s_q[1];
      end
   end

   logic rise, fall, tms_i, tdi_i;
   assign rise  = tck_s_q[1] && !tck_prev_q;
   assign fall  = !tck_s_q[1] && tck_prev_q;
   assign tms_i = tms_s_q[1];
   assign tdi_i = tdi_s_q[1];

   tbs_state_t          st_q, st_d;
   logic [IR_W-1:0]     irs_q, irs_d, ira_q, ira_d;
   logic [DR_W-1:0]     drs_q, drs_d, drp_q, drp_d;
   logic                byp_q, byp_d, tdo_q, tdo_d, oe_q, oe_d;
   logic [FIFO_W-1:0]   fbyte_q, fbyte_d;
   logic [2:0]          fcnt_q, fcnt_d;
   logic                fpush, f_ready;

   // next tap state
   function automatic tbs_state_t next_st(tbs_state_t s, logic m);
      unique case (s)
         ST_RESET:  next_st = m ? ST_RESET  : ST_IDLE;
         ST_IDLE:   next_st = m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: next_st = m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: next_st = m ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  next_st = m ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: next_st = m ? ST_UPD_DR : ST_PA_DR;
         ST_PA_DR:  next_st = m ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: next_st = m ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: next_st = m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: next_st = m ? ST_RESET  : ST_CAP_IR;
         ST_CAP_IR: next_st = m ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  next_st = m ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: next_st = m ? ST_UPD_IR : ST_PA_IR;
         ST_PA_IR:  next_st = m ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: next_st = m ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: next_st = m ? ST_SEL_DR : ST_IDLE;
         default:   next_st = ST_RESET;
      endcase
   endfunction : next_st

   logic is_byp;
   assign is_byp = (ira_q == IR_BYPASS);

   // tap datapath next values
   always_comb begin
      st_d    = st_q;
      irs_d   = irs_q;
      ira_d   = ira_q;
      drs_d   = drs_q;
      drp_d   = drp_q;
      byp_d   = byp_q;
      tdo_d   = tdo_q;
      oe_d    = oe_q;
      fbyte_d = fbyte_q;
      fcnt_d  = fcnt_q;
      fpush   = 1'b0;
      if (rise) begin
         st_d = next_st(st_q, tms_i);
         unique case (st_q)
            ST_CAP_IR: irs_d = IR_CAPTURE;
            ST_SH_IR:  irs_d = {tdi_i, irs_q[IR_W-1:1]};
            ST_CAP_DR: begin
               byp_d = 1'b0;
               drs_d = drp_q;
            end
            ST_SH_DR: begin
               if (is_byp) byp_d = tdi_i;
               else drs_d = {tdi_i, drs_q[DR_W-1:1]};
               fbyte_d = {tdi_i, fbyte_q[FIFO_W-1:1]};
               fcnt_d  = fcnt_q + 3'h1;
               fpush   = (fcnt_q == 3'h7) && f_ready;
            end
            default: ;
         endcase
         if (st_q == ST_RESET) ira_d = IR_RESET;
      end
      if (fall) begin
         unique case (st_q)
            ST_UPD_IR: ira_d = irs_q;
            ST_UPD_DR: if (!is_byp) drp_d = drs_q;
            ST_RESET:  ira_d = IR_RESET;
            default: ;
         endcase
         oe_d  = (st_q == ST_SH_DR) || (st_q == ST_SH_IR);
         tdo_d = (st_q == ST_SH_IR) ? irs_q[0] : (is_byp ? byp_q : drs_q[0]);
      end
   end

   // tap registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_q    <= ST_RESET;
         irs_q   <= '0;
         ira_q   <= IR_RESET;
         drs_q   <= '0;
         drp_q   <= '0;
         byp_q   <= 1'b0;
         tdo_q   <= 1'b0;
         oe_q    <= 1'b0;
         fbyte_q <= '0;
         fcnt_q  <= '0;
      end else begin
         st_q    <= st_d;
         irs_q   <= irs_d;
         ira_q   <= ira_d;
         drs_q   <= drs_d;
         drp_q   <= drp_d;
         byp_q   <= byp_d;
         tdo_q   <= tdo_d;
         oe_q    <= oe_d;
         fbyte_q <= fbyte_d;
         fcnt_q  <= fcnt_d;
      end
   end

   // shifted-in bytes buffered for the user side
   tbs_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (fpush),
      .in_ready  (f_ready),
      .in_data   ({tdi_i, fbyte_q[FIFO_W-1:1]}),
      .out_valid (word_valid),
      .out_ready (word_ready),
      .out_data  (word_data)
   );

   assign tdo         = tdo_q;
   assign tdo_oe      = oe_q;
   assign ir_active   = ira_q;
   assign bypass_sel  = is_byp;
   assign dr_parallel = drp_q;
   assign tlr_state   = (st_q == ST_RESET);

   property p_cap_zero;
      @(posedge clk) disable iff (!reset_n)
      (rise && st_q == ST_CAP_DR) |=> !byp_q;
   endproperty
   a_cap_zero: assert property (p_cap_zero) else $error("bypass not zero after capture");
   property p_upd_ir;
      @(posedge clk) disable iff (!reset_n)
      (fall && st_q == ST_UPD_IR) |=> (ira_q == $past(irs_q));
   endproperty
   a_upd_ir: assert property (p_upd_ir) else $error("instruction not loaded");
   property p_oe_sh;
      @(posedge clk) disable iff (!reset_n)
      (fall && st_q == ST_SH_DR) |=> tdo_oe;
   endproperty
   a_oe_sh: assert property (p_oe_sh) else $error("tdo not enabled in shift");
   property p_oe_ex;
      @(posedge clk) disable iff (!reset_n)
      (fall && st_q == ST_EX1_DR) |=> !tdo_oe;
   endproperty
   a_oe_ex: assert property (p_oe_ex) else $error("tdo not released in exit1");
   property p_shift;
      @(posedge clk) disable iff (!reset_n)
      (rise && st_q == ST_SH_DR && is_byp) |=> (byp_q == $past(tdi_i));
   endproperty
   a_shift: assert property (p_shift) else $error("bypass did not shift");
   property p_byp_out;
      @(posedge clk) disable iff (!reset_n)
      (fall && st_q == ST_SH_DR && is_byp) |=> (tdo == $past(byp_q));
   endproperty
   a_byp_out: assert property (p_byp_out) else $error("bypass output wrong");
   property p_upd_dr;
      @(posedge clk) disable iff (!reset_n)
      (fall && st_q == ST_UPD_DR && !is_byp) |=> (drp_q == $past(drs_q));
   endproperty
   a_upd_dr: assert property (p_upd_dr) else $error("parallel stage not updated");
   property p_cap_ir;
      @(posedge clk) disable iff (!reset_n)
      (rise && st_q == ST_CAP_IR) |=> (irs_q == IR_CAPTURE);
   endproperty
   a_cap_ir: assert property (p_cap_ir) else $error("ir capture wrong");
   property p_tlr;
      @(posedge clk) disable iff (!reset_n)
      (rise && st_q == ST_SEL_IR && tms_i) |=> tlr_state;
   endproperty
   a_tlr: assert property (p_tlr) else $error("reset state not reached");
   property p_stable;
      @(posedge clk) disable iff (!reset_n)
      (!rise) |=> (st_q == $past(st_q));
   endproperty
   a_stable: assert property (p_stable) else $error("state moved without rising edge");
endmodule : tbs_tap

// >>> testbench/tbs_ctl_model.sv
`timescale 1ns/100ps
// scan controller on the far side of the test port
module tbs_ctl_model (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   // test clock stands high between frames
   initial begin
      tck = 1'b1;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // one test clock period of 160 ns; tdo seen just before the rise
   // launch on falling edge
   task automatic step(input logic m, input logic d, output logic o, output logic e);
      tck = 1'b0;
      tms = m;
      tdi = d;
      #75;
      o = tdo_oe ? tdo : 1'bZ; // released line reads as floating
      e = tdo_oe;
      #5 tck = 1'b1;
      #80;
   endtask : step
endmodule : tbs_ctl_model

// >>> testbench/tbs_tap_tb.sv
`timescale 1ns/100ps
module tbs_tap_tb;
   import tbs_pkg::*;
   typedef struct {logic [7:0] ir; int n; logic [7:0] din; logic [7:0] exp;} tbs_row_t;
   logic         clk, reset_n, tck, tms, tdi, tdo, tdo_oe, bypass_sel, tlr_state;
   logic         word_valid, word_ready;
   logic [7:0]   ir_active, dr_parallel, word_data, so;
   logic [135:0] stream;
   int           fail_count = 0;
   int           check_count = 0;
   int           cyc = 0;
   tbs_row_t     rows [3];

   tbs_tap u_dut (.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe(tdo_oe), .ir_active(ir_active), .bypass_sel(bypass_sel), .dr_parallel(dr_parallel),
      .tlr_state(tlr_state), .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
   tbs_ctl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

   // system clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic chk_bit(input string s, input logic x, input logic y);
      check_count++;
      if (y !== x) begin
         fail_count++;
         $display("ERROR %s expected %b seen %b", s, x, y);
      end
   endtask : chk_bit

   task automatic chk_byte(input string s, input logic [7:0] x, input logic [7:0] y);
      check_count++;
      if (y !== x) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", s, x, y);
      end
   endtask : chk_byte

   task automatic tally_and_finish();
      if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   // non-shift step, data line toggled so it never holds a stale value
   task automatic nav(input logic m);
      logic o, e;
      u_ctl.step(m, ~tdi, o, e);
   endtask : nav

   // one scan from idle, back to idle or to test-logic-reset
   // state walk
   task automatic scan(input bit ir, input logic [135:0] v, input int n, input bit to_tlr);
      logic o, e;
      nav(1'b1);
      if (ir) nav(1'b1);
      nav(1'b0);
      nav(1'b0);
      so = '0;
      for (int i = 0; i < n; i++) begin
         u_ctl.step(i == n - 1, v[i], o, e);
         if (i < 8) so[i] = o;
         chk_bit("tdo_oe shift", 1'b1, e);
      end
      u_ctl.step(1'b1, ~tdi, o, e);
      chk_bit("tdo_oe exit1", 1'b0, e);
      if (to_tlr) repeat (3) nav(1'b1);
      else nav(1'b0);
   endtask : scan

   // main sequence
   initial begin
      reset_n = 1'b0;
      word_ready = 1'b1;
      rows[0] = '{8'hFF, 3, 8'h05, 8'h02};
      rows[1] = '{8'h00, 8, 8'hA5, 8'hA5};
      rows[2] = '{8'hFF, 8, 8'h3C, 8'h78};
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      #7;
      chk_bit("tdo_oe reset", 1'b0, tdo_oe);
      chk_byte("ir_active reset", IR_RESET, ir_active);
      chk_bit("tlr_state reset", 1'b1, tlr_state);
      chk_bit("word_valid reset", 1'b0, word_valid);
      nav(1'b0);
      // table of ir and dr scans
      foreach (rows[k]) begin
         scan(1'b1, {128'h0, rows[k].ir}, 8, 1'b0);
         chk_byte("ir capture", IR_CAPTURE, so);
         chk_byte("ir_active", rows[k].ir, ir_active);
         chk_bit("bypass_sel", rows[k].ir == IR_BYPASS, bypass_sel);
         scan(1'b0, {128'h0, rows[k].din}, rows[k].n, 1'b0);
         if (rows[k].ir == IR_BYPASS) chk_byte("tdo stream", rows[k].exp, so);
         else chk_byte("dr_parallel", rows[k].exp, dr_parallel);
      end
      // single-bit scan shows the captured zero, then back to reset
      scan(1'b0, 136'h1, 1, 1'b1);
      chk_byte("bypass capture", 8'h00, so);
      chk_bit("tlr_state", 1'b1, tlr_state);
      // second reset in mid-run, then fill the word buffer with reader stalled
      @(posedge clk);
      reset_n <= 1'b0;
      word_ready <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      nav(1'b0);
      for (int b = 0; b < 17; b++) stream[b*8 +: 8] = 8'(8'h40 + b);
      scan(1'b0, stream, 136, 1'b0);
      // drain: 16 words in order, the 17th refused
      for (int b = 0; b < 16; b++) begin
         chk_bit("word_valid", 1'b1, word_valid);
         chk_byte("word_data", 8'(8'h40 + b), word_data);
         @(posedge clk);
         word_ready <= 1'b1;
         @(posedge clk);
         word_ready <= 1'b0;
         #1;
      end
      chk_bit("word_valid empty", 1'b0, word_valid);
      tally_and_finish();
   end
endmodule : tbs_tap_tb
